/* bcd_pkg.sv */
// boot configuration driver constants: preset words, timing and state codes
// assumes a 50 MHz controller clock
package bcd_pkg;
    localparam int unsigned CLK_HZ        = 50000000;
    localparam int unsigned RST_HOLD_MS   = 100;
    localparam int unsigned RST_HOLD_CYC  = (CLK_HZ / 1000) * RST_HOLD_MS;
    localparam int unsigned SUPPLY_SETTLE_US  = 10;
    localparam int unsigned SUPPLY_SETTLE_CYC = (CLK_HZ / 1000000) * SUPPLY_SETTLE_US;
    localparam int unsigned CFG_HOLD_US   = 10;
    localparam int unsigned CFG_HOLD_CYC  = (CLK_HZ / 1000000) * CFG_HOLD_US;
    localparam int unsigned CFG_W         = 32;
    localparam int unsigned CNT_W         = 23;
    // preset words; sd: bits 7,21,31; emmc adds 4,6,11,15,16
    localparam logic [31:0] CFG_SD_WORD   = 32'h8020_0080;
    localparam logic [31:0] CFG_EMMC_WORD = 32'h8021_88d0;
    localparam logic [31:0] CFG_IDLE_WORD = 32'h0000_0000;
    // boot-mode line codes {line1, line0}
    localparam logic [1:0]  BM_SERIAL_VIRGIN = 2'h0;
    // register map of the command port
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_STATUS    = 4'h1;
    localparam logic [3:0]  REG_CFG_WORD  = 4'h2;
    localparam int unsigned CTRL_SUPPLY_EN_BIT = 0;
    localparam int unsigned CTRL_RESEQ_BIT     = 1;
    localparam logic [31:0] CTRL_RESET_VAL     = 32'h0000_0001;

    typedef enum logic [4:0]
    {
        ST_OFF    = 5'h01,
        ST_SETTLE = 5'h02,
        ST_HOLD   = 5'h04,
        ST_EXTEND = 5'h08,
        ST_RUN    = 5'h10
    } bcd_state_t;

    typedef enum logic [1:0]
    {
        BOOT_SERIAL_VIRGIN = 2'h0,
        BOOT_SERIAL_PROG   = 2'h1,
        BOOT_CFG_WORD      = 2'h2
    } bcd_boot_t;
endpackage

/* bcd_sync.sv */
// two-flop synchroniser bank for pin inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/1ns
module bcd_sync #(
    parameter int unsigned W = 1
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    input  wire logic [W-1:0] rst_val,
    output      logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // reset loads a constant; rst_val is only sampled while out of reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else
        begin
            meta_r <= d ^ rst_val;
            q      <= meta_r ^ rst_val;
        end
    end
endmodule

/* bcd_boot_config_driver.sv */
// boot configuration driver: power/reset sequencer and reset configuration word
// assumes REF_CLK 50 MHz, SYS_RST synchronous; switch, strap and reset pins are asynchronous
//
// Operation
// RQ1: drive all 32 configuration lines from presets
// RQ2: dip switch picks the active preset
// RQ3: storage off=sd, on=emmc; core off=apps
// RQ4: sd bits 7,21,31; emmc adds five
// RQ5: presets matter only in configuration-word boot
// RQ6: serial download ignores dip switch setting
// RQ7: boot line low when strap or slider
// RQ8: decode boot lines into three boot modes
// RQ9: line0 to port pc9, line1 pc10
// RQ10: supply enable low leaves carrier unpowered
// RQ11: reset released 100 ms; request extends
// RQ12: configuration held stable across reset release
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module bcd_boot_config_driver
(
    input  wire logic                     REF_CLK,
    input  wire logic                     SYS_RST,
    input  wire logic                     STORAGE_SELECT_SWITCH,
    input  wire logic                     CORE_SELECT_SWITCH,
    input  wire logic                     BOOT_MODE_SLIDER,
    input  wire logic                     STRAP0_INSTALLED,
    input  wire logic                     STRAP1_INSTALLED,
    input  wire logic                     SUPPLY_GOOD,
    input  wire logic                     EXTERNAL_RESET_REQUEST_N,
    input  wire logic [3:0]               REG_ADDR,
    input  wire logic [31:0]              REG_WDATA,
    input  wire logic                     REG_WR,
    input  wire logic                     REG_RD,
    output      logic [31:0]              REG_RDATA,
    output      logic [bcd_pkg::CFG_W-1:0] RESET_CONFIG_WORD,
    output      logic                     RESET_CONFIG_OE,
    output      logic                     BOOT_MODE_LINE0,
    output      logic                     BOOT_MODE_LINE1,
    output      logic                     PROC_RESET_N,
    output      logic                     CORE_SELECT_RT,
    output      logic                     CARRIER_SUPPLY_ENABLE
);
    import bcd_pkg::*;

    logic [6:0]         pins_s;
    logic               storage_s;
    logic               core_s;
    logic               slider_s;
    logic               strap0_s;
    logic               strap1_s;
    logic               supply_s;
    logic               ext_req_n_s;
    bcd_state_t         state_r;
    bcd_state_t         state_nxt;
    logic [CNT_W-1:0]   cnt_r;
    logic [CNT_W-1:0]   cnt_nxt;
    logic [31:0]        ctrl_r;
    logic [31:0]        cfg_word_r;
    logic               core_rt_r;
    logic               line0_r;
    logic               line1_r;
    logic               rst_n_r;
    logic               supply_en_r;
    logic               reseq_req_r;
    logic               ext_req_d_r;
    logic               ext_fall;
    bcd_boot_t          boot_mode;
    logic [31:0]        rdata_r;

    // all strap and switch pins pass two flops before use
    bcd_sync #(.W(7)) u_sync
    (
        .clk     (REF_CLK),
        .rst     (SYS_RST),
        .d       ({STORAGE_SELECT_SWITCH, CORE_SELECT_SWITCH, BOOT_MODE_SLIDER,
                   STRAP0_INSTALLED, STRAP1_INSTALLED, SUPPLY_GOOD, EXTERNAL_RESET_REQUEST_N}),
        .rst_val (7'h01),
        .q       (pins_s)
    );

    assign storage_s   = pins_s[6];
    assign core_s      = pins_s[5];
    assign slider_s    = pins_s[4];
    assign strap0_s    = pins_s[3];
    assign strap1_s    = pins_s[2];
    assign supply_s    = pins_s[1];
    assign ext_req_n_s = pins_s[0];

    function automatic logic [31:0] preset_word(input logic emmc);
        // storage select off means sd slot, on means emmc
        preset_word = emmc ? CFG_EMMC_WORD : CFG_SD_WORD; // [RQ3] [RQ4]
    endfunction

    function automatic bcd_boot_t decode_boot(input logic l1, input logic l0);
        if ({l1, l0} == BM_SERIAL_VIRGIN)
            decode_boot = BOOT_SERIAL_VIRGIN;
        // line0 only stays high with strap0 off and the slider in serial position
        else if (l0)
            decode_boot = BOOT_SERIAL_PROG;
        else
            decode_boot = BOOT_CFG_WORD; // [RQ8]
    endfunction

    assign ext_fall  = ext_req_d_r & ~ext_req_n_s;
    // registered lines only, so the drive enable cannot glitch while the slider moves
    assign boot_mode = decode_boot(line1_r, line0_r);

    // boot-mode lines: low when strap fitted or slider pulls that line
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            line0_r <= 1'b0;
            line1_r <= 1'b0;
        end
        else
        begin
            // slider position 0 pulls line0, position 1 pulls line1
            line0_r <= ~(strap0_s | ~slider_s); // [RQ7]
            line1_r <= ~(strap1_s | slider_s); // [RQ7]
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            ext_req_d_r <= 1'b1;
        else
            ext_req_d_r <= ext_req_n_s;
    end

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            ST_OFF:
            begin
                if (supply_s & ctrl_r[CTRL_SUPPLY_EN_BIT])
                begin
                    state_nxt = ST_SETTLE;
                    cnt_nxt   = CNT_W'(SUPPLY_SETTLE_CYC - 1);
                end
            end
            ST_SETTLE:
            begin
                if (cnt_r == '0)
                begin
                    state_nxt = ST_HOLD;
                    cnt_nxt   = CNT_W'(RST_HOLD_CYC - 1);
                end
                else
                    cnt_nxt = cnt_r - 1'b1;
            end
            ST_HOLD:
            begin
                if (cnt_r != '0)
                    cnt_nxt = cnt_r - 1'b1;
                else if (!ext_req_n_s)
                    state_nxt = ST_HOLD; // [RQ11]
                else
                begin
                    state_nxt = ST_EXTEND;
                    cnt_nxt   = CNT_W'(CFG_HOLD_CYC - 1);
                end
            end
            ST_EXTEND:
            begin
                // a request arriving here would otherwise be missed by the edge detector
                if (!ext_req_n_s)
                begin
                    state_nxt = ST_HOLD;
                    cnt_nxt   = CNT_W'(RST_HOLD_CYC - 1); // [RQ11]
                end
                else if (cnt_r == '0)
                    state_nxt = ST_RUN;
                else
                    cnt_nxt = cnt_r - 1'b1;
            end
            ST_RUN:
            begin
                if (ext_fall | reseq_req_r)
                begin
                    state_nxt = ST_HOLD;
                    cnt_nxt   = CNT_W'(RST_HOLD_CYC - 1); // [RQ11]
                end
            end
        endcase
        if (!supply_s | !ctrl_r[CTRL_SUPPLY_EN_BIT])
        begin
            state_nxt = ST_OFF;
            cnt_nxt   = '0;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            state_r <= ST_OFF;
            cnt_r   <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // word latched only while reset is asserted, so the processor samples a stable value
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            cfg_word_r <= CFG_IDLE_WORD;
            core_rt_r  <= 1'b0;
        end
        else if (state_r == ST_OFF || state_r == ST_SETTLE)
        begin
            cfg_word_r <= preset_word(storage_s); // [RQ1] [RQ2] [RQ12]
            core_rt_r  <= core_s; // [RQ3]
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            rst_n_r     <= 1'b0;
            supply_en_r <= 1'b0;
        end
        else
        begin
            rst_n_r     <= (state_nxt == ST_RUN); // [RQ11]
            supply_en_r <= supply_s & ctrl_r[CTRL_SUPPLY_EN_BIT]; // [RQ10]
        end
    end

    // control register; reseq bit self-clears after one cycle
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            ctrl_r      <= CTRL_RESET_VAL;
            reseq_req_r <= 1'b0;
        end
        else
        begin
            reseq_req_r <= REG_WR && REG_ADDR == REG_CTRL && REG_WDATA[CTRL_RESEQ_BIT];
            if (REG_WR && REG_ADDR == REG_CTRL)
                ctrl_r <= {31'h0, REG_WDATA[CTRL_SUPPLY_EN_BIT]};
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            rdata_r <= 32'h0;
        else if (REG_RD)
        begin
            unique case (REG_ADDR)
                REG_CTRL:     rdata_r <= ctrl_r;
                REG_STATUS:   rdata_r <= {22'h0, boot_mode, state_r, core_rt_r, rst_n_r, supply_en_r};
                REG_CFG_WORD: rdata_r <= cfg_word_r;
                default:      rdata_r <= 32'h0;
            endcase
        end
        else
            rdata_r <= 32'h0;
    end

    assign REG_RDATA             = rdata_r;
    // lines are actively driven only when the carrier is powered
    assign RESET_CONFIG_WORD     = cfg_word_r;
    // serial boot ignores the word; the drive enable stays low, so the lines are not driven
    assign RESET_CONFIG_OE       = supply_en_r & (boot_mode == BOOT_CFG_WORD); // [RQ5] [RQ6]
    assign BOOT_MODE_LINE0       = line0_r; // [RQ9]
    assign BOOT_MODE_LINE1       = line1_r; // [RQ9]
    assign PROC_RESET_N          = rst_n_r;
    assign CORE_SELECT_RT        = core_rt_r;
    assign CARRIER_SUPPLY_ENABLE = supply_en_r; // [RQ10]
endmodule

/* bcd_boot_config_driver_asserts.sv */
// checker: port assertions of the boot configuration driver
// assumes one clock domain with a synchronous reset on SYS_RST
`timescale 1ns/1ns
module bcd_boot_config_driver_asserts
    import bcd_pkg::*;
(
    input wire logic           REF_CLK,
    input wire logic           SYS_RST,
    input wire logic           STORAGE_SELECT_SWITCH,
    input wire logic           BOOT_MODE_SLIDER,
    input wire logic           STRAP0_INSTALLED,
    input wire logic           STRAP1_INSTALLED,
    input wire logic           SUPPLY_GOOD,
    input wire logic           EXTERNAL_RESET_REQUEST_N,
    input wire logic [CFG_W-1:0] RESET_CONFIG_WORD,
    input wire logic           RESET_CONFIG_OE,
    input wire logic           BOOT_MODE_LINE0,
    input wire logic           BOOT_MODE_LINE1,
    input wire logic           PROC_RESET_N,
    input wire logic           CARRIER_SUPPLY_ENABLE
);
    default clocking dc @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);
    // pins pass two sync flops plus state and output flops, hence the repeat counts
    logic [22:0] low_cnt_r;
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST || PROC_RESET_N || !CARRIER_SUPPLY_ENABLE)
            low_cnt_r <= 23'h0;
        else if (low_cnt_r != 23'h7fffff)
            low_cnt_r <= low_cnt_r + 23'h1;
    end
    sequence s_release;
        !PROC_RESET_N ##1 PROC_RESET_N;
    endsequence
    sequence s_serial;
        BOOT_MODE_SLIDER [*6];
    endsequence
    sequence s_off_steady;
        (!CARRIER_SUPPLY_ENABLE && $stable(STORAGE_SELECT_SWITCH)) [*8];
    endsequence
    cfg_oe_a: assert property (RESET_CONFIG_OE |-> CARRIER_SUPPLY_ENABLE && BOOT_MODE_LINE1 && !BOOT_MODE_LINE0)
        else $error("config drive without supply");
    word_decode_a: assert property (s_off_steady |->
        RESET_CONFIG_WORD == (STORAGE_SELECT_SWITCH ? CFG_EMMC_WORD : CFG_SD_WORD))
        else $error("wrong preset word");
    word_stable_a: assert property (PROC_RESET_N |-> $stable(RESET_CONFIG_WORD))
        else $error("word moved after release");
    release_hold_a: assert property (s_release |-> low_cnt_r >= RST_HOLD_CYC)
        else $error("reset released early");
    supply_drop_a: assert property (!SUPPLY_GOOD [*6] |-> !CARRIER_SUPPLY_ENABLE)
        else $error("supply enable without good supply");
    virgin_lines_a: assert property ((STRAP0_INSTALLED && STRAP1_INSTALLED) [*6]
        |-> !BOOT_MODE_LINE0 && !BOOT_MODE_LINE1)
        else $error("boot lines not low");
    line0_high_a: assert property ((!STRAP0_INSTALLED && BOOT_MODE_SLIDER) [*6]
        |-> BOOT_MODE_LINE0)
        else $error("line0 low without pull");
    line1_high_a: assert property ((!STRAP1_INSTALLED && !BOOT_MODE_SLIDER) [*6]
        |-> BOOT_MODE_LINE1)
        else $error("line1 low without pull");
    serial_no_oe_a: assert property (s_serial |-> !RESET_CONFIG_OE)
        else $error("config drive in serial mode");
    ext_hold_a: assert property (!EXTERNAL_RESET_REQUEST_N [*6] |-> !PROC_RESET_N)
        else $error("reset released during request");
endmodule
bind bcd_boot_config_driver bcd_boot_config_driver_asserts u_chk (.REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST), .STORAGE_SELECT_SWITCH(STORAGE_SELECT_SWITCH),
    .BOOT_MODE_SLIDER(BOOT_MODE_SLIDER), .STRAP0_INSTALLED(STRAP0_INSTALLED),
    .STRAP1_INSTALLED(STRAP1_INSTALLED), .SUPPLY_GOOD(SUPPLY_GOOD),
    .EXTERNAL_RESET_REQUEST_N(EXTERNAL_RESET_REQUEST_N), .RESET_CONFIG_WORD(RESET_CONFIG_WORD),
    .RESET_CONFIG_OE(RESET_CONFIG_OE), .BOOT_MODE_LINE0(BOOT_MODE_LINE0),
    .BOOT_MODE_LINE1(BOOT_MODE_LINE1), .PROC_RESET_N(PROC_RESET_N),
    .CARRIER_SUPPLY_ENABLE(CARRIER_SUPPLY_ENABLE));

/* bcd_proc_model.sv */
// processor side: captures the configuration word when its reset is released
// assumes sampling on controller clock edges, where the lines are registered
`timescale 1ns/1ns
module bcd_proc_model
(
    input  wire logic        clk,
    input  wire logic [31:0] cfg_word,
    input  wire logic        cfg_oe,
    input  wire logic        reset_n,
    output      logic        taken,
    output      logic [31:0] sampled
);
    logic prev_r = 1'b0;
    initial taken = 1'b0;
    always @(posedge clk)
    begin
        prev_r <= reset_n;
        if (reset_n && !prev_r)
        begin
            taken <= 1'b1;
            // lines mean nothing unless configuration-word boot is strapped
            sampled <= cfg_oe ? cfg_word : 32'h0;
        end
    end
endmodule

/* bcd_boot_config_driver_tb_top.sv */
// testbench: scenarios for the boot configuration driver
// assumes package counts; the 100 ms hold is too long to run up to release
`timescale 1ns/1ns
module bcd_boot_config_driver_tb_top;
    import bcd_pkg::*;
    logic        clk, rst, sto, core, sld, s0, s1, sg, ext_n, wr, rd;
    logic        oe, l0, l1, prn, crt, sup, taken;
    logic [3:0]  addr;
    logic [31:0] wd, rdat, word, d;
    int          n_mismatch = 0;
    int          check_count = 0;
    bcd_boot_config_driver uut (.REF_CLK(clk), .SYS_RST(rst), .STORAGE_SELECT_SWITCH(sto),
        .CORE_SELECT_SWITCH(core), .BOOT_MODE_SLIDER(sld), .STRAP0_INSTALLED(s0),
        .STRAP1_INSTALLED(s1), .SUPPLY_GOOD(sg), .EXTERNAL_RESET_REQUEST_N(ext_n),
        .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
        .RESET_CONFIG_WORD(word), .RESET_CONFIG_OE(oe), .BOOT_MODE_LINE0(l0),
        .BOOT_MODE_LINE1(l1), .PROC_RESET_N(prn), .CORE_SELECT_RT(crt),
        .CARRIER_SUPPLY_ENABLE(sup));
    bcd_proc_model proc (.clk(clk), .cfg_word(word), .cfg_oe(oe), .reset_n(prn),
        .taken(taken), .sampled());
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdat;
    endtask
    // order {storage, core, slider, strap0, strap1, supply_good}; waits out sync and output flops
    task automatic pins(input logic [5:0] p);
        @(posedge clk);
        {sto, core, sld, s0, s1, sg} <= p;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic wait_sup(input logic e);
        int n;
        n = 0;
        while (sup !== e && n < 600)
        begin
            @(posedge clk);
            #1 n++;
        end
        cmp(sup, e);
        if (sup !== e)
            summarize;
    endtask
    task automatic t_regs;
        rd_reg(REG_CTRL);
        cmp(d, CTRL_RESET_VAL);
        wr_reg(4'hf, 32'hffff_ffff);
        rd_reg(4'hf);
        cmp(d, 32'h0);
        $display("regs done");
    endtask
    task automatic t_word;
        for (int i = 0; i < 4; i++)
        begin
            pins({i[0], i[1], 4'b0110});
            cmp(word, i[0] ? CFG_EMMC_WORD : CFG_SD_WORD);
            cmp(crt, i[1]);
            rd_reg(REG_CFG_WORD);
            cmp(d, i[0] ? CFG_EMMC_WORD : CFG_SD_WORD);
        end
        $display("word done");
    endtask
    // rows {strap0, strap1, slider, line1, line0, config drive}
    task automatic t_boot;
        logic [5:0] c [7];
        c = '{6'h30, 6'h10, 6'h1a, 6'h25, 6'h05, 6'h0a, 6'h28};
        pins(6'h07);
        wait_sup(1'b1);
        foreach (c[k])
        begin
            pins({2'b00, c[k][3], c[k][5:4], 1'b1});
            cmp({l1, l0}, c[k][2:1]);
            cmp(oe, c[k][0]);
        end
        $display("boot done");
    endtask
    task automatic t_freeze;
        repeat (600) @(posedge clk);
        pins(6'h25);
        cmp(word, CFG_SD_WORD);
        cmp(oe, 1'b1);
        ext_n <= 1'b0;
        repeat (20) @(posedge clk);
        #1 cmp(prn, 1'b0);
        cmp(taken, 1'b0);
        @(posedge clk);
        ext_n <= 1'b1;
        $display("freeze done");
    endtask
    task automatic t_off;
        wr_reg(REG_CTRL, 32'h0);
        wait_sup(1'b0);
        pins(6'h25);
        cmp(oe, 1'b0);
        cmp(word, CFG_EMMC_WORD);
        rd_reg(REG_STATUS);
        cmp(d[0], 1'b0);
        wr_reg(REG_CTRL, 32'h1);
        wait_sup(1'b1);
        pins(6'h24);
        wait_sup(1'b0);
        $display("off done");
    endtask
    initial
    begin
        {rst, sto, core, sld, s0, s1, sg, ext_n, wr, rd} = 10'b1000110100;
        addr = 4'h0;
        wd = 32'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_word;
        t_boot;
        t_freeze;
        t_off;
        summarize;
    end
endmodule
